// ==== hdl/scsc_pkg.sv ====
// package: register map, field layout and timing constants of the clock source block
package scsc_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_INT_CTRL = 8'h00;
    localparam logic [7:0] ADDR_INT_CAL = 8'h04;
    localparam logic [7:0] ADDR_EXT_CTRL = 8'h08;
    localparam logic [7:0] ADDR_CLK_SRC = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h14;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1C;
    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int INT_EN_BIT = 7;
    localparam int DIV_LSB = 0;
    localparam logic [1:0] DIV_RST = 2'h3;
    localparam logic [6:0] CAL_RST = 7'h40;
    localparam int EXT_MODE_LSB = 4;
    localparam int FREQ_LSB = 0;
    localparam int XVALID_BIT = 7;
    localparam int IRQ_W = 3;
    localparam int IRQ_XVALID = 0;
    localparam int IRQ_SWITCH = 1;
    localparam int IRQ_XLOST = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ------------------------------------------------------------
    // external oscillator modes
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_CMOS = 3'h2;
    localparam logic [2:0] MODE_RC = 3'h4;
    localparam logic [2:0] MODE_CAP = 3'h5;
    localparam logic [2:0] MODE_XTAL = 3'h6;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int XSETTLE_US = 1000;
    localparam int XSETTLE_CYC = XSETTLE_US * CLK_MHZ;
    localparam int SYNC_STAGES = 2;
    typedef enum logic [1:0] {SCSC_RUN, SCSC_DROP, SCSC_PICK} scsc_sw_t;
endpackage : scsc_pkg

// ==== hdl/scsc_divider.sv ====
// module: internal oscillator post-divider, ratio 1, 2, 4 or 8
`timescale 1ns/100ps
module scsc_divider
    import scsc_pkg::*;
(
    input wire logic osc_i,
    input wire logic rst_i,
    input wire logic [1:0] sel_i,
    output logic clk_o
);
    logic [2:0] cnt_r;
    // ratios 2, 4 and 8 tap a free-running counter bit; ratio 1 passes the oscillator straight through
    always_ff @(posedge osc_i or posedge rst_i)
    begin
        if (rst_i)
            cnt_r <= 3'h0;
        else
            cnt_r <= cnt_r + 3'h1;
    end
    always_comb
    begin
        unique case (sel_i)
            2'h0: clk_o = osc_i;
            2'h1: clk_o = cnt_r[0];
            2'h2: clk_o = cnt_r[1];
            2'h3: clk_o = cnt_r[2];
        endcase
    end
endmodule : scsc_divider

// ==== hdl/scsc_sync.sv ====
// module: two flip-flop level synchroniser
`timescale 1ns/100ps
module scsc_sync
    import scsc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic d_i,
    output logic q_o
);
    logic [SYNC_STAGES-1:0] ff_r;
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            ff_r <= '0;
        else
            ff_r <= {ff_r[SYNC_STAGES-2:0], d_i};
    end
    assign q_o = ff_r[SYNC_STAGES-1];
endmodule : scsc_sync

// ==== hdl/scsc_top.sv ====
// module: system clock source control with AXI4-Lite register slave
// Operation
// (RL1) reset runs the system clock from the internal oscillator
// (RL2) internal path divides by 1, 2, 4 or 8 per divide field
// (RL3) the divide field resets to divide by eight
// (RL4) calibration register trims internal period, nominally 24.5 MHz
// (RL5) select bit 1 picks external oscillator, 0 the internal path
// (RL6) external clock stays available to timers while internal runs system
// (RL7) source may switch at run time; software picks only settled sources
// (RL8) internal oscillator may be selected straight after enabling it
// (RL9) hardware sets the crystal valid flag once external has settled
// (RL10) in crystal mode software waits 1 ms before testing valid flag
// (RL11) software sets external type and frequency field for its source
// (RL12) crystal mode takes two pins; other external modes only output pin
// (RL13) software makes the crossbar skip oscillator pins
// (RL14) oscillator pins analog, or digital input in CMOS mode
// (RL15) crystal start: pins low, analog, enable, wait, poll, switch
// (RL16) RC and capacitor modes need no start-up time
// (RL17) tuning-fork crystals need extra settling before trusting valid flag
// (RL18) clock mux hands over glitch-free on clean edges of both clocks
//
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
module scsc_top
    import scsc_pkg::*;
#(
    parameter int SETTLE_CYC = XSETTLE_CYC
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic int_osc_i,
    input wire logic ext_osc_i,
    input wire logic ext_amp_ok_i,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [6:0] int_osc_cal_o,
    output logic int_osc_en_o,
    output logic [2:0] ext_osc_mode_o,
    output logic [2:0] ext_freq_control_o,
    output logic crystal_input_pin_take_o,
    output logic crystal_output_pin_take_o,
    output logic ext_clk_periph_o,
    output logic sys_clk_o,
    output logic irq_o
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic int_en_r;
    logic [1:0] div_sel_r;
    logic [6:0] cal_r;
    logic [2:0] ext_mode_r;
    logic [2:0] freq_ctl_r;
    logic src_sel_r;
    logic [31:0] settle_cnt_r;
    logic xvalid_r;
    logic [IRQ_W-1:0] irq_stat_r;
    logic [IRQ_W-1:0] irq_en_r;
    logic [7:0] awaddr_r;
    logic aw_hold_r;
    logic [31:0] wdata_r;
    logic w_hold_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic [1:0] bresp_r;
    logic bvalid_r;
    logic rvalid_r;
    logic wr_fire;
    logic wr_ok;
    logic [IRQ_W-1:0] irq_clr;
    logic [IRQ_W-1:0] irq_set;
    logic int_div_clk;
    logic sel_int_r;
    logic sel_ext_r;
    logic int_on_ext;
    logic ext_on_int;
    logic ext_run_sync;
    logic int_run_sync;
    logic xvalid_q;
    logic ext_active;
    logic wstrb0_r;
    logic ext_xtal_start;
    logic int_off_sync;
    logic sel_idle_q;
    // ------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------
    assign s_axi_awready = !aw_hold_r && !bvalid_r;
    assign s_axi_wready = !w_hold_r && !bvalid_r;
    assign wr_fire = aw_hold_r && w_hold_r && !bvalid_r;
    assign wr_ok = awaddr_r <= ADDR_STATUS && awaddr_r[1:0] == 2'h0;
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h00000000;
            wstrb0_r <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            else if (wr_fire)
                aw_hold_r <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb0_r <= s_axi_wstrb[0];
            end
            else if (wr_fire)
                w_hold_r <= 1'b0;
        end
    end
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_r <= 1'b0;
    end
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    // ------------------------------------------------------------
    // control registers; byte lane 0 carries every field
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            int_en_r <= 1'b1;
            div_sel_r <= DIV_RST; // RL3
            cal_r <= CAL_RST;
            ext_mode_r <= MODE_OFF;
            freq_ctl_r <= 3'h0;
            src_sel_r <= 1'b0; // RL1
            irq_en_r <= '0;
        end
        else if (wr_fire && wstrb0_r)
        begin
            unique case (awaddr_r)
                ADDR_INT_CTRL:
                begin
                    int_en_r <= wdata_r[INT_EN_BIT];
                    div_sel_r <= wdata_r[DIV_LSB +: 2]; // RL2
                end
                ADDR_INT_CAL: cal_r <= wdata_r[6:0]; // RL4
                ADDR_EXT_CTRL:
                begin
                    ext_mode_r <= wdata_r[EXT_MODE_LSB +: 3];
                    freq_ctl_r <= wdata_r[FREQ_LSB +: 3];
                end
                ADDR_CLK_SRC: src_sel_r <= wdata_r[0]; // RL7
                ADDR_IRQ_EN: irq_en_r <= wdata_r[IRQ_W-1:0];
                default: ;
            endcase
        end
    end
    assign irq_clr = (wr_fire && wstrb0_r && awaddr_r == ADDR_IRQ_CLR)
        ? wdata_r[IRQ_W-1:0] : '0;
    // ------------------------------------------------------------
    // external oscillator settle detection
    // ------------------------------------------------------------
    // crystal waits the settle time and amplitude detect; rc and cap are ready at once
    assign ext_active = ext_mode_r != MODE_OFF;
    // entering crystal mode restarts the settle count, so a stale valid cannot carry over
    assign ext_xtal_start = wr_fire && wstrb0_r && awaddr_r == ADDR_EXT_CTRL
        && wdata_r[EXT_MODE_LSB +: 3] == MODE_XTAL && ext_mode_r != MODE_XTAL;
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            settle_cnt_r <= 32'h00000000;
            xvalid_r <= 1'b0;
        end
        else if (!ext_active || ext_xtal_start)
        begin
            settle_cnt_r <= 32'h00000000;
            xvalid_r <= 1'b0;
        end
        else if (ext_mode_r == MODE_XTAL)
        begin
            if (settle_cnt_r < SETTLE_CYC)
                settle_cnt_r <= settle_cnt_r + 32'h1;
            xvalid_r <= settle_cnt_r >= SETTLE_CYC && ext_amp_ok_i; // RL9
        end
        else
            xvalid_r <= 1'b1; // RL16
    end
    // ------------------------------------------------------------
    // interrupt status
    // ------------------------------------------------------------
    assign irq_set[IRQ_XVALID] = xvalid_r && !xvalid_q;
    assign irq_set[IRQ_XLOST] = !xvalid_r && xvalid_q;
    // the selected side's gate comes from another clock, so it is resynchronised first
    scsc_sync u_sync_sw (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(src_sel_r ? !ext_run_sync : !int_run_sync),
        .q_o(sel_idle_q)
    );
    assign irq_set[IRQ_SWITCH] = !sel_idle_q && !ext_on_int;
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            xvalid_q <= 1'b0;
            irq_stat_r <= '0;
            ext_on_int <= 1'b1;
        end
        else
        begin
            xvalid_q <= xvalid_r;
            ext_on_int <= !sel_idle_q;
            // a set in the clearing cycle wins
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
        end
    end
    assign irq_o = |(irq_stat_r & irq_en_r);
    // ------------------------------------------------------------
    // register read
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_r <= 1'b1;
            rresp_r <= RESP_OKAY;
            rdata_r <= 32'h00000000;
            unique case (s_axi_araddr)
                ADDR_INT_CTRL: rdata_r <= {24'h0, int_en_r, 5'h0, div_sel_r};
                ADDR_INT_CAL: rdata_r <= {25'h0, cal_r};
                ADDR_EXT_CTRL: rdata_r <= {24'h0, xvalid_r, ext_mode_r, 1'b0, freq_ctl_r};
                ADDR_CLK_SRC: rdata_r <= {31'h0, src_sel_r};
                ADDR_IRQ_STAT: rdata_r <= {29'h0, irq_stat_r};
                ADDR_IRQ_EN: rdata_r <= {29'h0, irq_en_r};
                ADDR_IRQ_CLR: rdata_r <= 32'h00000000;
                ADDR_STATUS: rdata_r <= {30'h0, sel_ext_r, sel_int_r};
                default: rresp_r <= RESP_SLVERR;
            endcase
        end
        else if (s_axi_rready)
            rvalid_r <= 1'b0;
    end
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    // ------------------------------------------------------------
    // oscillator outputs and pin ownership
    // ------------------------------------------------------------
    assign int_osc_en_o = int_en_r;
    assign int_osc_cal_o = cal_r; // RL4
    assign ext_osc_mode_o = ext_mode_r;
    assign ext_freq_control_o = freq_ctl_r;
    assign crystal_input_pin_take_o = ext_mode_r == MODE_XTAL; // RL12
    assign crystal_output_pin_take_o = ext_active; // RL12
    assign ext_clk_periph_o = ext_osc_i; // RL6
    // ------------------------------------------------------------
    // glitch-free clock mux
    // ------------------------------------------------------------
    // each side turns on only on its own falling edge after the other side is off
    scsc_divider u_div (
        .osc_i(int_osc_i),
        .rst_i(rst_i),
        .sel_i(div_sel_r),
        .clk_o(int_div_clk)
    ); // RL2
    scsc_sync u_sync_int (
        .clk_i(int_div_clk),
        .rst_i(rst_i),
        .d_i(src_sel_r || sel_ext_r),
        .q_o(int_off_sync)
    );
    scsc_sync u_sync_ext (
        .clk_i(ext_osc_i),
        .rst_i(rst_i),
        .d_i(src_sel_r && !sel_int_r),
        .q_o(ext_run_sync)
    );
    always_ff @(negedge int_div_clk or posedge rst_i)
    begin
        if (rst_i)
            sel_int_r <= 1'b1; // RL1
        else
            sel_int_r <= int_on_ext; // RL18
    end
    always_ff @(negedge ext_osc_i or posedge rst_i)
    begin
        if (rst_i)
            sel_ext_r <= 1'b0;
        else
            sel_ext_r <= ext_run_sync; // RL18
    end
    // the internal side carries the off request, so reset leaves its clock running
    assign int_on_ext = !int_off_sync;
    assign int_run_sync = int_on_ext;
    assign sys_clk_o = (int_div_clk & sel_int_r) | (ext_osc_i & sel_ext_r); // RL5
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_reset_div_eight: assert property (@(posedge clk_i)
        $fell(rst_i) |-> div_sel_r == DIV_RST) else $error("divider not 8 after reset"); // RL3
    a_reset_src_int: assert property (@(posedge clk_i)
        $fell(rst_i) |-> !src_sel_r) else $error("source not internal after reset"); // RL1
    a_mux_exclusive: assert property (@(posedge clk_i) disable iff (rst_i)
        !(sel_int_r && sel_ext_r)) else $error("both clocks gated on"); // RL18
    a_valid_rc_fast: assert property (@(posedge clk_i) disable iff (rst_i)
        (ext_mode_r == MODE_RC || ext_mode_r == MODE_CAP) ##1 (ext_mode_r == MODE_RC
        || ext_mode_r == MODE_CAP) |-> xvalid_r) else $error("rc valid late"); // RL16
    a_valid_needs_wait: assert property (@(posedge clk_i) disable iff (rst_i)
        (ext_mode_r == MODE_XTAL && xvalid_r) |-> settle_cnt_r >= SETTLE_CYC)
        else $error("crystal valid too early"); // RL9
    a_xtal_pins: assert property (@(posedge clk_i) disable iff (rst_i)
        crystal_input_pin_take_o |-> crystal_output_pin_take_o)
        else $error("crystal pin pair split"); // RL12
    a_cal_drive: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_fire && wstrb0_r && awaddr_r == ADDR_INT_CAL) |=> int_osc_cal_o
        == 7'($past(wdata_r))) else $error("calibration not applied"); // RL4
    a_div_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_fire && wstrb0_r && awaddr_r == ADDR_INT_CTRL) |=> div_sel_r
        == 2'($past(wdata_r))) else $error("divide field not applied"); // RL2
    a_src_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_fire && wstrb0_r && awaddr_r == ADDR_CLK_SRC) |=> src_sel_r
        == 1'($past(wdata_r))) else $error("source select not applied"); // RL5
    c_switch_ext: cover property (@(posedge clk_i) disable iff (rst_i) $rose(sel_ext_r));
    c_xtal_valid: cover property (@(posedge clk_i) disable iff (rst_i) $rose(xvalid_r));
    c_irq: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
endmodule : scsc_top

// ==== test/scsc_ext_osc_model.sv ====
// model of the external oscillator source: crystal, rc, capacitor or cmos clock
`timescale 1ns/100ps
module scsc_ext_osc_model
    import scsc_pkg::*;
#(
    parameter realtime HALF_NS = 15.0,
    parameter realtime START_NS = 2000.0
)
(
    input wire logic [2:0] mode_i,
    output logic osc_o,
    output logic amp_ok_o
);
    // ------------------------------------------------------------
    // oscillation, standing still while the drive is off
    // ------------------------------------------------------------
    initial osc_o = 1'b0;
    initial amp_ok_o = 1'b0;
    always
    begin
        if (mode_i inside {MODE_CMOS, MODE_RC, MODE_CAP, MODE_XTAL})
            #(HALF_NS) osc_o = ~osc_o;
        else
        begin
            osc_o = 1'b0;
            @(mode_i);
        end
    end
    // a crystal reaches good amplitude only after its start-up time
    always @(mode_i)
    begin
        amp_ok_o = 1'b0;
        if (mode_i == MODE_XTAL)
            amp_ok_o <= #(START_NS) 1'b1;
    end
endmodule : scsc_ext_osc_model

// ==== test/testbench.sv ====
// self-checking bench of the clock source block
`timescale 1ns/100ps
module testbench
    import scsc_pkg::*;
;
    localparam int SETTLE = 20;
    localparam int CEIL = 20000;
    localparam realtime WIN = 1536.0;
    typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} scsc_note_t;
    logic clk_i, rst_i, int_osc_i, ext_osc_i, ext_amp_ok_i;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, lfsr_r, v;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [6:0] int_osc_cal_o;
    logic [2:0] ext_osc_mode_o, ext_freq_control_o;
    logic int_osc_en_o, crystal_input_pin_take_o, crystal_output_pin_take_o;
    logic ext_clk_periph_o, sys_clk_o, irq_o;
    logic [2:0] md[3] = '{MODE_CMOS, MODE_RC, MODE_CAP};
    scsc_note_t rd_q[$];
    logic [1:0] wr_q[$];
    int bad_count, check_count, cyc, sys_n, per_n, k;

    scsc_top #(.SETTLE_CYC(SETTLE)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .int_osc_i(int_osc_i), .ext_osc_i(ext_osc_i),
        .ext_amp_ok_i(ext_amp_ok_i), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .int_osc_cal_o(int_osc_cal_o), .int_osc_en_o(int_osc_en_o),
        .ext_osc_mode_o(ext_osc_mode_o), .ext_freq_control_o(ext_freq_control_o),
        .crystal_input_pin_take_o(crystal_input_pin_take_o),
        .crystal_output_pin_take_o(crystal_output_pin_take_o),
        .ext_clk_periph_o(ext_clk_periph_o), .sys_clk_o(sys_clk_o), .irq_o(irq_o)
    );
    scsc_ext_osc_model osc_u (.mode_i(ext_osc_mode_o), .osc_o(ext_osc_i), .amp_ok_o(ext_amp_ok_i));

    // ------------------------------------------------------------
    // clocks, edge counters, timeout and result watcher
    // ------------------------------------------------------------
    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    initial
    begin
        int_osc_i = 1'b0;
        forever #6 int_osc_i = ~int_osc_i;
    end
    always @(posedge sys_clk_o) sys_n++;
    always @(posedge ext_clk_periph_o) per_n++;
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == CEIL)
        begin
            fail("run did not finish in time");
            end_of_test();
        end
    end
    // the watcher sees pre-edge values, so a handshake is judged where it happens
    always @(posedge clk_i)
    begin
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
            cmp_rd();
        if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
            cmp_wr();
    end

    function automatic logic [31:0] scsc_lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : scsc_lfsr
    task automatic fail(input string s);
        bad_count++;
        $display("wrong value at %0t: %s", $time, s);
    endtask : fail
    task automatic cmp_rd();
        scsc_note_t n;
        n = rd_q.pop_front();
        check_count++;
        if (((s_axi_rdata & n.m) !== (n.d & n.m)) || (s_axi_rresp !== n.r))
            fail($sformatf("read data %h resp %h", s_axi_rdata, s_axi_rresp));
    endtask : cmp_rd
    task automatic cmp_wr();
        check_count++;
        if (s_axi_bresp !== wr_q.pop_front())
            fail($sformatf("write resp %h", s_axi_bresp));
    endtask : cmp_wr
    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp, input string s);
        check_count++;
        if (got !== exp)
            fail($sformatf("%s got %h", s, got));
    endtask : cmp_val
    task automatic cmp_near(input int got, input int exp, input string s);
        check_count++;
        if (got > exp + 1 || got < exp - 1)
            fail($sformatf("%s got %0d", s, got));
    endtask : cmp_near
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st,
        input logic [1:0] r);
        bit ap;
        bit wp;
        wr_q.push_back(r);
        ap = 1'b1;
        wp = 1'b1;
        @(posedge clk_i);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= st;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (ap || wp)
        begin
            @(posedge clk_i);
            if (ap && s_axi_awready === 1'b1)
            begin
                s_axi_awvalid <= 1'b0;
                ap = 1'b0;
            end
            if (wp && s_axi_wready === 1'b1)
            begin
                s_axi_wvalid <= 1'b0;
                wp = 1'b0;
            end
        end
        do @(posedge clk_i); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
        input logic [1:0] r, output logic [31:0] q);
        rd_q.push_back('{d, m, r});
        @(posedge clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk_i); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk_i); while (s_axi_rvalid !== 1'b1);
        q = s_axi_rdata;
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic meas(input int es, input int ep);
        int a;
        int b;
        a = sys_n;
        b = per_n;
        #(WIN);
        cmp_near(sys_n - a, es, "system clock edges");
        cmp_near(per_n - b, ep, "peripheral clock edges");
    endtask : meas

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        rst_i = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
        lfsr_r = 32'hE629F1C1;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        meas(16, 0);
        rd(ADDR_INT_CTRL, 32'h83, 32'h83, RESP_OKAY, v);
        rd(ADDR_INT_CAL, 32'h40, 32'h7F, RESP_OKAY, v);
        rd(ADDR_CLK_SRC, 32'h0, 32'h1, RESP_OKAY, v);
        for (k = 0; k < 3; k++)
        begin
            lfsr_r = scsc_lfsr(lfsr_r);
            wr(ADDR_INT_CAL, lfsr_r, 4'hF, RESP_OKAY);
            cmp_val(int_osc_cal_o, lfsr_r[6:0], "calibration output");
        end
        // lane 0 disabled: the trim must not move
        wr(ADDR_INT_CAL, ~lfsr_r, 4'hE, RESP_OKAY);
        rd(ADDR_INT_CAL, lfsr_r, 32'h7F, RESP_OKAY, v);
        for (k = 0; k < 4; k++)
        begin
            wr(ADDR_INT_CTRL, 32'h80 | k, 4'hF, RESP_OKAY);
            repeat (60) @(posedge clk_i);
            meas(128 >> k, 0);
        end
        rd(8'h20, 32'h0, 32'h0, RESP_SLVERR, v);
        rd(8'h02, 32'h0, 32'h0, RESP_SLVERR, v);
        wr(8'h24, 32'h1, 4'hF, RESP_SLVERR);
        // crystal start: enable, wait the settle time, poll, then switch
        wr(ADDR_EXT_CTRL, {25'h0, MODE_XTAL, 4'h7}, 4'hF, RESP_OKAY);
        rd(ADDR_EXT_CTRL, 32'h67, 32'hF7, RESP_OKAY, v);
        cmp_val({crystal_input_pin_take_o, crystal_output_pin_take_o}, 2'b11, "pins");
        cmp_val({ext_osc_mode_o, ext_freq_control_o}, 6'h37, "ext fields");
        repeat (SETTLE) @(posedge clk_i);
        k = 0;
        v = 32'h0;
        while (v[7] !== 1'b1 && k < 200)
        begin
            rd(ADDR_EXT_CTRL, 32'h0, 32'h0, RESP_OKAY, v);
            k++;
        end
        cmp_val(v[7], 1'b1, "crystal valid");
        cmp_val(irq_o, 1'b0, "masked irq");
        wr(ADDR_IRQ_EN, 32'h1, 4'hF, RESP_OKAY);
        repeat (2) @(posedge clk_i);
        cmp_val(irq_o, 1'b1, "enabled irq");
        rd(ADDR_IRQ_STAT, 32'h1, 32'h7, RESP_OKAY, v);
        wr(ADDR_IRQ_CLR, 32'h1, 4'hF, RESP_OKAY);
        repeat (2) @(posedge clk_i);
        cmp_val(irq_o, 1'b0, "cleared irq");
        rd(ADDR_IRQ_CLR, 32'h0, 32'hFFFFFFFF, RESP_OKAY, v);
        meas(16, 51);
        wr(ADDR_CLK_SRC, 32'h1, 4'hF, RESP_OKAY);
        repeat (60) @(posedge clk_i);
        rd(ADDR_STATUS, 32'h2, 32'h3, RESP_OKAY, v);
        meas(51, 51);
        rd(ADDR_IRQ_STAT, 32'h2, 32'h3, RESP_OKAY, v);
        wr(ADDR_INT_CTRL, 32'h81, 4'hF, RESP_OKAY);
        wr(ADDR_CLK_SRC, 32'h0, 4'hF, RESP_OKAY);
        repeat (60) @(posedge clk_i);
        meas(64, 51);
        rd(ADDR_STATUS, 32'h1, 32'h3, RESP_OKAY, v);
        foreach (md[i])
        begin
            wr(ADDR_EXT_CTRL, {25'h0, md[i], 4'h0}, 4'hF, RESP_OKAY);
            rd(ADDR_EXT_CTRL, {24'h0, 1'b1, md[i], 4'h0}, 32'hF0, RESP_OKAY, v);
            cmp_val({crystal_input_pin_take_o, crystal_output_pin_take_o}, 2'b01, "pins");
        end
        wr(ADDR_EXT_CTRL, 32'h0, 4'hF, RESP_OKAY);
        cmp_val({crystal_input_pin_take_o, crystal_output_pin_take_o}, 2'b00, "pins");
        rd(ADDR_IRQ_STAT, 32'h4, 32'h4, RESP_OKAY, v);
        end_of_test();
    end
endmodule : testbench
